// File: design/udr_consts.svh
`ifndef UDR_CONSTS_SVH
`define UDR_CONSTS_SVH

// Register byte offsets
`define UDR_OFS_CTRL      8'h00
`define UDR_OFS_RATE      8'h04
`define UDR_OFS_FRAME     8'h08
`define UDR_OFS_STATUS    8'h0C
`define UDR_OFS_RX_COUNT  8'h10
`define UDR_OFS_RX_DATA   8'h14
`define UDR_OFS_TX_QUEUE  8'h18
`define UDR_OFS_TX_RAW    8'h1C
`define UDR_OFS_IRQ_STAT  8'h20
`define UDR_OFS_IRQ_MASK  8'h24
`define UDR_OFS_FLUSH     8'h28
`define UDR_OFS_LINE_LEN  8'h2C
`define UDR_OFS_LINE_DATA 8'h30

// Control fields
`define UDR_CTRL_EN       0
`define UDR_CTRL_TXIE     1
`define UDR_CTRL_RTS      2
// Status fields
`define UDR_ST_TX_BUSY    0
`define UDR_ST_CTS        1
`define UDR_ST_RX_AVAIL   2
`define UDR_ST_LINE_ACT   3
`define UDR_ST_TX_FULL    4
// Interrupt event bits
`define UDR_EV_RX_BYTE    0
`define UDR_EV_TX_DONE    1
`define UDR_EV_LINE_DONE  2
`define UDR_EV_FRAME_ERR  3
`define UDR_EV_W          4

// Reset values
`define UDR_RATE_DEFAULT  4'h9
`define UDR_FRAME_RESET   5'h03
`define UDR_CR_BYTE       8'h0D

// Oversampling and bit-rate table in baud
`define UDR_OVERSAMPLE    16
`define UDR_BAUD_1        110
`define UDR_BAUD_2        150
`define UDR_BAUD_3        300
`define UDR_BAUD_4        600
`define UDR_BAUD_5        1200
`define UDR_BAUD_6        2400
`define UDR_BAUD_7        4800
`define UDR_BAUD_8        9600
`define UDR_BAUD_9        19200
`define UDR_BAUD_10       38400
`define UDR_BAUD_11       57600
`define UDR_BAUD_12       115200
`define UDR_BAUD_13       250000
`define UDR_BAUD_14       500000
`define UDR_BAUD_15       1250000

`endif

// File: design/udr_pkg.sv
`default_nettype none
package udr_pkg;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} udr_rx_state_e;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} udr_tx_state_e;
  // Character framing: data bits = 5 + dbits
  typedef struct packed {
    logic       parity_odd;
    logic       parity_en;
    logic       two_stop;
    logic [1:0] dbits;
  } udr_frame_s;
endpackage : udr_pkg
`default_nettype wire

// File: design/udr_uart_dma_ring.sv
// Functional notes
// - Bit rate from system clock, max clk/16
// - Rate codes 1..15, code 9 default
// - Code selects divisor of clock/16
// - Reset framing 8N1, full duplex
// - Data, stop, parity bits software changeable
// - Receive DMA fills wrapping ring at head
// - Full ring overwrites oldest, no warning
// - Reception stops only on reset or close
// - Unread count is head minus tail
// - Pop from tail in FIFO order
// - Send while pointers differ, then disable interrupt
// - Busy clears when all data sent
// - Sending starts only with interrupt enabled
// - Line read stops at count or CR
// - No flow control; CTS readable, RTS settable
// - Close disables; flush resets receive pointers
// - Transmit and receive rates independent
`include "udr_consts.svh"
`default_nettype none
module udr_uart_dma_ring
  import udr_pkg::*;
#(
  parameter int SYS_CLK_HZ = 125_000_000,  // System clock rate
  parameter int RX_DEPTH   = 16,           // Receive ring bytes
  parameter int TX_DEPTH   = 16            // Transmit ring bytes
) (
  input  wire logic        ref_clk_i,   // System clock
  input  wire logic        sys_rst_i,   // Async reset, high
  input  wire logic [7:0]  addr_i,      // Register byte address
  input  wire logic [31:0] wdata_i,     // Write data
  input  wire logic        wr_i,        // Write strobe
  input  wire logic        rd_i,        // Read strobe
  output logic      [31:0] rdata_o,     // Read data, next cycle
  input  wire logic        rxd_i,       // Serial receive pin
  output logic             txd_o,       // Serial transmit pin
  input  wire logic        cts_n_i,     // Clear to send pin
  output logic             rts_n_o,     // Request to send pin
  output logic             irq_o        // Level interrupt
);

  localparam int RAW = $clog2(RX_DEPTH);
  localparam int TAW = $clog2(TX_DEPTH);

  // Rounded divisor for one rate code
  function automatic int rate_div(input int code);
    int baud;
    case (code)
      1:       baud = `UDR_BAUD_1;
      2:       baud = `UDR_BAUD_2;
      3:       baud = `UDR_BAUD_3;
      4:       baud = `UDR_BAUD_4;
      5:       baud = `UDR_BAUD_5;
      6:       baud = `UDR_BAUD_6;
      7:       baud = `UDR_BAUD_7;
      8:       baud = `UDR_BAUD_8;
      10:      baud = `UDR_BAUD_10;
      11:      baud = `UDR_BAUD_11;
      12:      baud = `UDR_BAUD_12;
      13:      baud = `UDR_BAUD_13;
      14:      baud = `UDR_BAUD_14;
      15:      baud = `UDR_BAUD_15;
      default: baud = `UDR_BAUD_9;
    endcase
    rate_div = (SYS_CLK_HZ + (`UDR_OVERSAMPLE * baud) / 2) / (`UDR_OVERSAMPLE * baud);
    if (rate_div < 1) rate_div = 1;
  endfunction : rate_div

  // Divisor table, one constant per code
  logic [19:0] div_tab [16];
  for (genvar g = 0; g < 16; g++) begin : g_div
    assign div_tab[g] = 20'(rate_div(g));
  end

  // Software state
  logic             port_en;
  logic             tx_ie;
  logic             rts;
  logic [3:0]       tx_code;
  logic [3:0]       rx_code;
  udr_frame_s       frame;
  logic [`UDR_EV_W-1:0] irq_stat;
  logic [`UDR_EV_W-1:0] irq_mask;
  logic [15:0]      line_left;
  logic             line_act;

  // Rings and pointers
  logic [7:0]       rx_mem [RX_DEPTH];
  logic [RAW-1:0]   rx_head;
  logic [RAW-1:0]   rx_tail;
  logic [RAW:0]     rx_count;
  logic [7:0]       tx_mem [TX_DEPTH];
  logic [TAW-1:0]   tx_head;
  logic [TAW-1:0]   tx_tail;
  logic [TAW:0]     tx_count;

  // Decodes
  logic wr_ctrl, wr_rate, wr_frame, wr_txq, wr_txr, wr_istat, wr_imask, wr_flush, wr_line;
  logic rd_pop, rd_line;
  assign wr_ctrl  = wr_i && addr_i == `UDR_OFS_CTRL;
  assign wr_rate  = wr_i && addr_i == `UDR_OFS_RATE;
  assign wr_frame = wr_i && addr_i == `UDR_OFS_FRAME;
  assign wr_txq   = wr_i && addr_i == `UDR_OFS_TX_QUEUE;
  assign wr_txr   = wr_i && addr_i == `UDR_OFS_TX_RAW;
  assign wr_istat = wr_i && addr_i == `UDR_OFS_IRQ_STAT;
  assign wr_imask = wr_i && addr_i == `UDR_OFS_IRQ_MASK;
  assign wr_flush = wr_i && addr_i == `UDR_OFS_FLUSH;
  assign wr_line  = wr_i && addr_i == `UDR_OFS_LINE_LEN;
  assign rd_line  = rd_i && addr_i == `UDR_OFS_LINE_DATA && line_act && rx_count != '0;
  assign rd_pop   = (rd_i && addr_i == `UDR_OFS_RX_DATA && rx_count != '0) || rd_line;

  // Pin synchronisers
  logic [1:0] rxd_sync;
  logic [1:0] cts_sync;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rxd_sync <= 2'b11;
      cts_sync <= 2'b11;
    end else begin
      rxd_sync <= {rxd_sync[0], rxd_i};
      cts_sync <= {cts_sync[0], cts_n_i};
    end
  end

  // Control and rate registers
  logic tx_emptied;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      port_en <= 1'b0;
      rts     <= 1'b0;
      tx_code <= `UDR_RATE_DEFAULT;
      rx_code <= `UDR_RATE_DEFAULT;
      frame   <= `UDR_FRAME_RESET;
    end else begin
      if (wr_ctrl) begin
        port_en <= wdata_i[`UDR_CTRL_EN];
        rts     <= wdata_i[`UDR_CTRL_RTS];
      end
      if (wr_rate && wdata_i[3:0] != 4'h0) tx_code <= wdata_i[3:0];
      if (wr_rate && wdata_i[7:4] != 4'h0) rx_code <= wdata_i[7:4];
      if (wr_frame) frame <= wdata_i[4:0];
    end
  end

  // Transmit interrupt enable
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_ie <= 1'b0;
    end else if (wr_txq && port_en) begin
      tx_ie <= 1'b1;
    end else if (wr_ctrl) begin
      tx_ie <= wdata_i[`UDR_CTRL_EN] && wdata_i[`UDR_CTRL_TXIE];
    end else if (!port_en || tx_emptied) begin
      tx_ie <= 1'b0;
    end
  end

  // Oversample tick generators
  logic [19:0] rx_div_cnt;
  logic [19:0] tx_div_cnt;
  logic        rx_tick;
  logic        tx_tick;
  assign rx_tick = rx_div_cnt == 20'h0_0000;
  assign tx_tick = tx_div_cnt == 20'h0_0000;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_div_cnt <= 20'h0_0000;
      tx_div_cnt <= 20'h0_0000;
    end else begin
      rx_div_cnt <= rx_tick ? div_tab[rx_code] - 20'h0_0001 : rx_div_cnt - 20'h0_0001;
      tx_div_cnt <= tx_tick ? div_tab[tx_code] - 20'h0_0001 : tx_div_cnt - 20'h0_0001;
    end
  end

  // Receiver
  udr_rx_state_e rx_st;
  logic [3:0]    rx_ph;
  logic [2:0]    rx_bit;
  logic [7:0]    rx_sh;
  logic          rx_par;
  logic          rx_store;
  logic          rx_ferr;
  logic [7:0]    rx_byte;
  logic          rx_in;
  assign rx_in   = rxd_sync[1];
  assign rx_byte = rx_sh >> (3'd3 - frame.dbits);
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_st    <= RX_IDLE;
      rx_ph    <= 4'h0;
      rx_bit   <= 3'h0;
      rx_sh    <= 8'h00;
      rx_par   <= 1'b0;
      rx_store <= 1'b0;
      rx_ferr  <= 1'b0;
    end else begin
      rx_store <= 1'b0;
      rx_ferr  <= 1'b0;
      if (!port_en) begin
        rx_st <= RX_IDLE;
      end else if (rx_tick) begin
        rx_ph <= rx_ph + 4'h1;
        case (rx_st)
          RX_IDLE: begin
            rx_ph <= 4'h0;
            if (!rx_in) rx_st <= RX_START;
          end
          RX_START: begin
            if (rx_ph == 4'h7) begin
              rx_ph  <= 4'h0;
              rx_bit <= 3'h0;
              rx_par <= frame.parity_odd;
              rx_st  <= rx_in ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rx_ph == 4'hF) begin
              rx_sh  <= {rx_in, rx_sh[7:1]};
              rx_par <= rx_par ^ rx_in;
              rx_bit <= rx_bit + 3'h1;
              if (rx_bit == {1'b1, frame.dbits}) rx_st <= frame.parity_en ? RX_PAR : RX_STOP;
            end
          end
          RX_PAR: begin
            if (rx_ph == 4'hF) begin
              rx_par <= rx_par ^ rx_in;
              rx_st  <= RX_STOP;
            end
          end
          RX_STOP: begin
            if (rx_ph == 4'hF) begin
              rx_st    <= RX_IDLE;
              rx_store <= rx_in && !(frame.parity_en && rx_par);
              rx_ferr  <= !rx_in || (frame.parity_en && rx_par);
            end
          end
          default: rx_st <= RX_IDLE;
        endcase
      end
    end
  end

  // Receive DMA into the ring
  always_ff @(posedge ref_clk_i) begin
    if (rx_store) rx_mem[rx_head] <= rx_byte;
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_head  <= '0;
      rx_tail  <= '0;
      rx_count <= '0;
    end else if (wr_flush) begin
      rx_head  <= '0;
      rx_tail  <= '0;
      rx_count <= '0;
    end else begin
      if (rx_store) rx_head <= rx_head + 1'b1;
      if (rx_pop_or_over()) rx_tail <= rx_tail + 1'b1;
      if (rx_store && !rd_pop && rx_count != RX_DEPTH[RAW:0]) rx_count <= rx_count + 1'b1;
      else if (!rx_store && rd_pop) rx_count <= rx_count - 1'b1;
    end
  end

  // Tail moves on a pop or when a full ring is overwritten
  function automatic logic rx_pop_or_over();
    rx_pop_or_over = rd_pop || (rx_store && rx_count == RX_DEPTH[RAW:0]);
  endfunction : rx_pop_or_over

  // Line read tracking
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      line_left <= 16'h0000;
      line_act  <= 1'b0;
    end else if (wr_line) begin
      line_left <= wdata_i[15:0];
      line_act  <= wdata_i[15:0] != 16'h0000;
    end else if (rd_line) begin
      line_left <= line_left - 16'h0001;
      if (line_left == 16'h0001 || rx_mem[rx_tail] == `UDR_CR_BYTE) line_act <= 1'b0;
    end
  end

  // Transmit ring fill
  logic tx_take;
  logic tx_push;
  assign tx_push = (wr_txq || wr_txr) && tx_count != TX_DEPTH[TAW:0];
  always_ff @(posedge ref_clk_i) begin
    if (tx_push) tx_mem[tx_head] <= wdata_i[7:0];
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_head  <= '0;
      tx_tail  <= '0;
      tx_count <= '0;
    end else begin
      if (tx_push) tx_head <= tx_head + 1'b1;
      if (tx_take) tx_tail <= tx_tail + 1'b1;
      if (tx_push && !tx_take) tx_count <= tx_count + 1'b1;
      else if (!tx_push && tx_take) tx_count <= tx_count - 1'b1;
    end
  end

  // Transmitter
  udr_tx_state_e tx_st;
  logic [3:0]    tx_ph;
  logic [2:0]    tx_bit;
  logic [7:0]    tx_sh;
  logic          tx_par;
  logic          tx_stop2;
  assign tx_take    = tx_st == TX_IDLE && tx_tick && tx_ie && port_en && tx_count != '0;
  assign tx_emptied = tx_st == TX_STOP && tx_tick && tx_ph == 4'hF && !tx_stop2 && tx_count == '0;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_st    <= TX_IDLE;
      tx_ph    <= 4'h0;
      tx_bit   <= 3'h0;
      tx_sh    <= 8'h00;
      tx_par   <= 1'b0;
      tx_stop2 <= 1'b0;
      txd_o    <= 1'b1;
    end else if (!port_en) begin
      tx_st <= TX_IDLE;
      txd_o <= 1'b1;
    end else if (tx_tick) begin
      tx_ph <= tx_ph + 4'h1;
      case (tx_st)
        TX_IDLE: begin
          tx_ph <= 4'h0;
          txd_o <= 1'b1;
          if (tx_take) begin
            tx_sh  <= tx_mem[tx_tail];
            tx_par <= frame.parity_odd;
            tx_bit <= 3'h0;
            tx_st  <= TX_START;
            txd_o  <= 1'b0;
          end
        end
        TX_START: begin
          if (tx_ph == 4'hF) begin
            tx_st <= TX_DATA;
            txd_o <= tx_sh[0];
          end
        end
        TX_DATA: begin
          if (tx_ph == 4'hF) begin
            tx_par <= tx_par ^ tx_sh[0];
            tx_sh  <= {1'b0, tx_sh[7:1]};
            tx_bit <= tx_bit + 3'h1;
            if (tx_bit == {1'b1, frame.dbits}) begin
              tx_st    <= frame.parity_en ? TX_PAR : TX_STOP;
              txd_o    <= frame.parity_en ? tx_par ^ tx_sh[0] : 1'b1;
              tx_stop2 <= frame.two_stop;
            end else begin
              txd_o <= tx_sh[1];
            end
          end
        end
        TX_PAR: begin
          if (tx_ph == 4'hF) begin
            tx_st <= TX_STOP;
            txd_o <= 1'b1;
          end
        end
        TX_STOP: begin
          if (tx_ph == 4'hF) begin
            tx_stop2 <= 1'b0;
            if (!tx_stop2) tx_st <= TX_IDLE;
          end
        end
        default: tx_st <= TX_IDLE;
      endcase
    end
  end

  // Sticky interrupt status, set beats clear
  logic [`UDR_EV_W-1:0] ev;
  assign ev = {rx_ferr, rd_line && line_left == 16'h0001 || rd_line && rx_mem[rx_tail] == `UDR_CR_BYTE,
               tx_emptied, rx_store};
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      irq_stat <= (irq_stat & ~(wr_istat ? wdata_i[`UDR_EV_W-1:0] : '0)) | ev;
      if (wr_imask) irq_mask <= wdata_i[`UDR_EV_W-1:0];
    end
  end
  assign irq_o = port_en && |(irq_stat & irq_mask);

  // Flow-control pins, no automatic action
  assign rts_n_o = !rts;

  // Read data, one cycle after the strobe
  logic tx_busy;
  assign tx_busy = tx_st != TX_IDLE || (tx_ie && tx_count != '0);
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      case (addr_i)
        `UDR_OFS_CTRL:      rdata_o <= {29'h0, rts, tx_ie, port_en};
        `UDR_OFS_RATE:      rdata_o <= {24'h0, rx_code, tx_code};
        `UDR_OFS_FRAME:     rdata_o <= {27'h0, frame};
        `UDR_OFS_STATUS:    rdata_o <= {27'h0, tx_count == TX_DEPTH[TAW:0], line_act, rx_count != '0,
                                        !cts_sync[1], tx_busy};
        `UDR_OFS_RX_COUNT:  rdata_o <= 32'(rx_count);
        `UDR_OFS_RX_DATA:   rdata_o <= rd_pop ? {24'h0, rx_mem[rx_tail]} : 32'h0000_0000;
        `UDR_OFS_IRQ_STAT:  rdata_o <= 32'(irq_stat);
        `UDR_OFS_IRQ_MASK:  rdata_o <= 32'(irq_mask);
        `UDR_OFS_LINE_LEN:  rdata_o <= {16'h0, line_left};
        `UDR_OFS_LINE_DATA: rdata_o <= rd_line ? {23'h0, 1'b1, rx_mem[rx_tail]} : 32'h0000_0000;
        default:            rdata_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule : udr_uart_dma_ring
`default_nettype wire

// File: testbench/udr_uart_dma_ring_asserts.sv
`include "udr_consts.svh"
`default_nettype none
module udr_uart_dma_ring_asserts (
  input wire logic        ref_clk_i, // Clock
  input wire logic        sys_rst_i, // Reset
  input wire logic [7:0]  addr_i,    // Address
  input wire logic [31:0] wdata_i,   // Write data
  input wire logic        wr_i,      // Write strobe
  input wire logic        rd_i,      // Read strobe
  input wire logic [31:0] rdata_o,   // Read data
  input wire logic        txd_o,     // Serial out
  input wire logic        cts_n_i,   // Clear to send
  input wire logic        rts_n_o,   // Request to send
  input wire logic        irq_o      // Interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  logic       en_q;    // Port open as written
  logic       armed_q; // Sending ever enabled
  logic [7:0] low_run; // Cycles of low line
  // Software view of open and sending enable
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      en_q    <= 1'b0;
      armed_q <= 1'b0;
    end else if (wr_i && addr_i == `UDR_OFS_CTRL) begin
      en_q    <= wdata_i[`UDR_CTRL_EN];
      armed_q <= armed_q | wdata_i[`UDR_CTRL_TXIE];
    end else if (wr_i && addr_i == `UDR_OFS_TX_QUEUE) begin
      armed_q <= 1'b1;
    end
  end
  // Length of the current low stretch
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      low_run <= 8'h00;
    end else if (txd_o) begin
      low_run <= 8'h00;
    end else if (low_run != 8'hff) begin
      low_run <= low_run + 8'h01;
    end
  end
  property p_rts;
    wr_i && addr_i == `UDR_OFS_CTRL |=> rts_n_o == !$past(wdata_i[`UDR_CTRL_RTS]);
  endproperty
  a_rts: assert property (p_rts) else $error("rts pin does not follow control");
  property p_cts;
    (cts_n_i == 1'b0) [*4] ##0 (rd_i && addr_i == `UDR_OFS_STATUS) |=> rdata_o[`UDR_ST_CTS];
  endproperty
  a_cts: assert property (p_cts) else $error("cts level not reported");
  property p_closed_irq;
    !en_q && !$past(en_q) |-> !irq_o;
  endproperty
  a_closed_irq: assert property (p_closed_irq) else $error("interrupt while closed");
  property p_closed_txd;
    !en_q [*3] |-> txd_o;
  endproperty
  a_closed_txd: assert property (p_closed_txd) else $error("line active while closed");
  property p_raw;
    !armed_q |-> txd_o;
  endproperty
  a_raw: assert property (p_raw) else $error("sending without enable");
  property p_bit;
    $rose(txd_o) |-> low_run >= 8'h10;
  endproperty
  a_bit: assert property (p_bit) else $error("bit shorter than sixteen clocks");
  property p_mask;
    wr_i && addr_i == `UDR_OFS_IRQ_MASK && wdata_i[3:0] == 4'h0 ##1
      !(wr_i && addr_i == `UDR_OFS_IRQ_MASK) |=> !irq_o;
  endproperty
  a_mask: assert property (p_mask) else $error("interrupt with all masked");
  property p_hole;
    rd_i && addr_i == 8'hfc |=> rdata_o == 32'h0000_0000;
  endproperty
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
endmodule : udr_uart_dma_ring_asserts
bind udr_uart_dma_ring udr_uart_dma_ring_asserts udr_uart_dma_ring_asserts_i (
  .ref_clk_i(ref_clk_i),
  .sys_rst_i(sys_rst_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .txd_o(txd_o),
  .cts_n_i(cts_n_i),
  .rts_n_o(rts_n_o),
  .irq_o(irq_o)
);
`default_nettype wire

// File: testbench/udr_serial_peer.sv
`default_nettype none
module udr_serial_peer (
  input  wire logic clk_i,  // Bench clock
  input  wire logic line_i, // Device transmit pin
  output logic      line_o  // Device receive pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int         bit_clks = 96; // Listening bit time
  logic [7:0] got_q[$];      // Bytes heard
  initial line_o = 1'b1;
  // One 8N1 character, LSB first, idle high after
  task automatic send(input logic [7:0] b, input int bt);
    line_o <= 1'b0;
    repeat (bt) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      line_o <= b[i];
      repeat (bt) @(posedge clk_i);
    end
    line_o <= 1'b1;
    repeat (bt) @(posedge clk_i);
  endtask : send
  // Sample device characters mid-bit
  initial begin : hear
    logic [7:0] b;
    forever begin
      @(negedge line_i);
      repeat (bit_clks / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_clks) @(posedge clk_i);
        b[i] = line_i;
      end
      repeat (bit_clks) @(posedge clk_i);
      got_q.push_back(b);
    end
  end
endmodule : udr_serial_peer
`default_nettype wire

// File: testbench/udr_uart_dma_ring_tb_top.sv
`include "udr_consts.svh"
`default_nettype none
module udr_uart_dma_ring_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          BT = 96;            // Bit clocks at code 15
  localparam logic [31:0] Z  = 32'h0000_0000; // Zero word
  logic        ref_clk_i, sys_rst_i, wr_i, rd_i, rxd_i, txd_o, cts_n_i, rts_n_o, irq_o;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, rdata_o;
  int          bad_count, check_count;
  udr_uart_dma_ring #(.RX_DEPTH(4)) udr_uart_dma_ring_i (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd_i), .txd_o(txd_o),
    .cts_n_i(cts_n_i), .rts_n_o(rts_n_o), .irq_o(irq_o));
  udr_serial_peer udr_serial_peer_i (.clk_i(ref_clk_i), .line_i(txd_o), .line_o(rxd_i));
  // Clock
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr
  // Register read, data in the following cycle
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(nm, e, rdata_o);
  endtask : rc
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : idle
  task automatic wait_peer(input int n);
    int k;
    k = 0;
    while (udr_serial_peer_i.got_q.size() < n && k < 20000) begin
      @(posedge ref_clk_i);
      k++;
    end
    chk("peer bytes", 32'(n), 32'(udr_serial_peer_i.got_q.size()));
    if (udr_serial_peer_i.got_q.size() < n) conclude();
  endtask : wait_peer
  task automatic t_reset();
    rc("rate", `UDR_OFS_RATE, 32'h0000_0099);
    rc("frame", `UDR_OFS_FRAME, 32'h0000_0003);
    rc("count", `UDR_OFS_RX_COUNT, Z);
    rc("hole", 8'hfc, Z);
    for (int c = 1; c < 16; c++) begin
      wr(`UDR_OFS_RATE, 32'(c * 17));
      rc("code", `UDR_OFS_RATE, 32'(c * 17));
    end
    wr(`UDR_OFS_RATE, Z);
    rc("code zero", `UDR_OFS_RATE, 32'h0000_00ff);
  endtask : t_reset
  task automatic t_pins();
    cts_n_i <= 1'b0;
    idle(4);
    rc("cts low", `UDR_OFS_STATUS, 32'h0000_0002);
    cts_n_i <= 1'b1;
    idle(4);
    rc("cts high", `UDR_OFS_STATUS, Z);
    wr(`UDR_OFS_CTRL, 32'h0000_0004);
    chk("rts set", Z, 32'(rts_n_o));
    wr(`UDR_OFS_CTRL, Z);
    chk("rts clear", 32'h0000_0001, 32'(rts_n_o));
  endtask : t_pins
  // Raw byte held until enabled, then interrupt handling
  task automatic t_raw();
    wr(`UDR_OFS_CTRL, 32'h0000_0001);
    wr(`UDR_OFS_TX_RAW, 32'h0000_0041);
    idle(4 * BT);
    chk("held", Z, 32'(udr_serial_peer_i.got_q.size()));
    wr(`UDR_OFS_CTRL, 32'h0000_0003);
    wait_peer(1);
    chk("raw byte", 32'h0000_0041, 32'(udr_serial_peer_i.got_q.pop_front()));
    idle(BT);
    rc("ie off", `UDR_OFS_CTRL, 32'h0000_0001);
    rc("not busy", `UDR_OFS_STATUS, Z);
    rc("drained", `UDR_OFS_IRQ_STAT, 32'h0000_0002);
    wr(`UDR_OFS_IRQ_MASK, 32'h0000_0002);
    idle(2);
    chk("irq on", 32'h0000_0001, 32'(irq_o));
    wr(`UDR_OFS_IRQ_MASK, Z);
    idle(2);
    chk("irq masked", Z, 32'(irq_o));
    wr(`UDR_OFS_IRQ_MASK, 32'h0000_0002);
    wr(`UDR_OFS_IRQ_STAT, 32'h0000_0002);
    idle(2);
    chk("irq cleared", Z, 32'(irq_o));
  endtask : t_raw
  // Queue three bytes while two arrive
  task automatic t_duplex();
    logic [7:0] exp [3] = '{8'h55, 8'ha0, 8'h0d};
    foreach (exp[i]) wr(`UDR_OFS_TX_QUEUE, 32'(exp[i]));
    rc("busy", `UDR_OFS_STATUS, 32'h0000_0001);
    udr_serial_peer_i.send(8'h11, BT);
    udr_serial_peer_i.send(8'h22, BT);
    wait_peer(3);
    foreach (exp[i]) chk("queued", 32'(exp[i]), 32'(udr_serial_peer_i.got_q[i]));
    udr_serial_peer_i.got_q.delete();
    rc("count two", `UDR_OFS_RX_COUNT, 32'h0000_0002);
    rc("first", `UDR_OFS_RX_DATA, 32'h0000_0011);
    rc("second", `UDR_OFS_RX_DATA, 32'h0000_0022);
    rc("empty pop", `UDR_OFS_RX_DATA, Z);
  endtask : t_duplex
  task automatic t_wrap();
    for (int i = 1; i < 6; i++) udr_serial_peer_i.send(8'(i), BT);
    rc("full", `UDR_OFS_RX_COUNT, 32'h0000_0004);
    for (int i = 2; i < 6; i++) rc("newest", `UDR_OFS_RX_DATA, 32'(i));
    udr_serial_peer_i.send(8'h66, BT);
    wr(`UDR_OFS_FLUSH, 32'h0000_0001);
    rc("flushed", `UDR_OFS_RX_COUNT, Z);
  endtask : t_wrap
  task automatic t_line();
    udr_serial_peer_i.send(8'h41, BT);
    udr_serial_peer_i.send(8'h0d, BT);
    udr_serial_peer_i.send(8'h43, BT);
    wr(`UDR_OFS_LINE_LEN, 32'h0000_0005);
    rc("line a", `UDR_OFS_LINE_DATA, 32'h0000_0141);
    rc("line cr", `UDR_OFS_LINE_DATA, 32'h0000_010d);
    rc("line end", `UDR_OFS_LINE_DATA, Z);
    rc("line rest", `UDR_OFS_RX_COUNT, 32'h0000_0001);
  endtask : t_line
  // Even parity expected, peer sends a wrong one
  task automatic t_parity();
    wr(`UDR_OFS_IRQ_STAT, 32'h0000_000f);
    wr(`UDR_OFS_FRAME, 32'h0000_000b);
    rc("frame set", `UDR_OFS_FRAME, 32'h0000_000b);
    udr_serial_peer_i.send(8'h03, BT);
    idle(2 * BT);
    rc("parity event", `UDR_OFS_IRQ_STAT, 32'h0000_0008);
    rc("dropped", `UDR_OFS_RX_COUNT, 32'h0000_0001);
    wr(`UDR_OFS_FRAME, 32'h0000_0003);
    wr(`UDR_OFS_FLUSH, Z);
  endtask : t_parity
  // Send at code 15 while receiving at code 14
  task automatic t_rate();
    wr(`UDR_OFS_RATE, 32'h0000_00ef);
    wr(`UDR_OFS_TX_QUEUE, 32'h0000_003c);
    udr_serial_peer_i.send(8'h5a, 256);
    wait_peer(1);
    chk("fast tx", 32'h0000_003c, 32'(udr_serial_peer_i.got_q.pop_front()));
    rc("slow rx", `UDR_OFS_RX_DATA, 32'h0000_005a);
  endtask : t_rate
  task automatic t_close();
    wr(`UDR_OFS_RATE, 32'h0000_00ff);
    wr(`UDR_OFS_IRQ_MASK, 32'h0000_000f);
    wr(`UDR_OFS_CTRL, Z);
    udr_serial_peer_i.send(8'h77, BT);
    idle(BT);
    rc("closed rx", `UDR_OFS_RX_COUNT, Z);
    chk("closed irq", Z, 32'(irq_o));
  endtask : t_close
  // Main sequence
  initial begin
    sys_rst_i = 1'b1;
    wr_i      = 1'b0;
    rd_i      = 1'b0;
    addr_i    = 8'h00;
    wdata_i   = Z;
    cts_n_i   = 1'b1;
    repeat (4) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_pins();
    t_raw();
    t_duplex();
    t_wrap();
    t_line();
    t_parity();
    t_rate();
    t_close();
    conclude();
  end
endmodule : udr_uart_dma_ring_tb_top
`default_nettype wire
